// *** rtl/rpr_pkg.sv ***
// constants and types shared by the reset and powerdown return logic
package rpr_pkg;
    localparam int unsigned RPR_PULLDOWN_STATES = 16;
    localparam int unsigned RPR_STATE_CYCLES = 1;
    localparam logic [23:0] RPR_RESET_VECTOR = 24'hFF2080;
    localparam int unsigned RPR_EXT_ADDR_W = 20;
    localparam logic [23:0] RPR_EXT_WIN_LO = 24'hFF2000;
    localparam logic [23:0] RPR_EXT_WIN_HI = 24'hFF2FFF;
    localparam logic [1:0] RPR_MULT_STANDARD = 2'h0;
    localparam logic [1:0] RPR_MULT_RESERVED = 2'h2;
    localparam logic [1:0] RPR_MULT_DOUBLED = 2'h1;
    localparam logic [1:0] RPR_MULT_QUAD = 2'h3;
    localparam logic [2:0] RPR_FACTOR_X1 = 3'h1;
    localparam logic [2:0] RPR_FACTOR_X2 = 3'h2;
    localparam logic [2:0] RPR_FACTOR_X4 = 3'h4;
    localparam logic [1:0] RPR_SYNC_RESET = 2'h3;
    localparam logic RPR_PIN_IDLE = 1'b1;

    typedef enum logic [2:0] {
        RPR_ST_RUN,
        RPR_ST_IDLE,
        RPR_ST_STANDBY,
        RPR_ST_PDOWN,
        RPR_ST_WAKE
    } rpr_mode_t;
endpackage

// *** rtl/rpr_pd_if.sv ***
// handshake between the sequencer and the pull-down pulse timer
`timescale 1ns/1ps
`default_nettype none
interface rpr_pd_if;
    logic start;
    logic busy;
    modport ctrl (output start, input busy);
    modport timer (input start, output busy);
endinterface
`default_nettype wire

// *** rtl/rpr_pulldown_timer.sv ***
// pull-down pulse timer counting state times
`timescale 1ns/1ps
`default_nettype none
module rpr_pulldown_timer
    import rpr_pkg::*;
#(
    parameter int unsigned STATES = RPR_PULLDOWN_STATES,
    parameter int unsigned STATE_CYC = RPR_STATE_CYCLES
) (
    input wire logic ref_clk_i, // state clock
    input wire logic rst_i,     // async reset, high
    rpr_pd_if.timer pd          // start and busy
);
    localparam int CW = $clog2(STATES + 1);
    localparam int DW = $clog2(STATE_CYC + 1);
    localparam logic [CW-1:0] STATES_C = CW'(STATES);
    localparam logic [DW-1:0] DIV_LAST = DW'(STATE_CYC - 1);

    logic [CW-1:0] cnt_r;
    logic [DW-1:0] div_r;
    logic busy_r;
    wire state_tick = (div_r == DIV_LAST);
    wire last_state = (cnt_r == CW'(1)) && state_tick;

    //////////////////////////////////////////////////////////////////
    // state time divider and pulse counter
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            div_r <= '0;
            busy_r <= 1'b0;
        end else if (pd.start) begin
            cnt_r <= STATES_C;
            div_r <= '0;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            div_r <= state_tick ? '0 : div_r + DW'(1);
            if (state_tick) begin
                cnt_r <= cnt_r - CW'(1);
            end
            if (last_state) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign pd.busy = busy_r;
endmodule // rpr_pulldown_timer
`default_nettype wire

// *** rtl/rpr_reset_seq.sv ***
// reset pin, pull-down pulse, powerdown return and fetch address logic
`timescale 1ns/1ps
`default_nettype none
module rpr_reset_seq
    import rpr_pkg::*;
#(
    parameter int unsigned PD_STATES = RPR_PULLDOWN_STATES,
    parameter int unsigned STATE_CYC = RPR_STATE_CYCLES
) (
    input wire logic ref_clk_i,                      // state clock
    input wire logic rst_i,                          // async reset, high
    input wire logic reset_pin_i,                    // reset pin level, low = reset
    output logic reset_pin_o,                        // reset pin drive value, always low
    output logic reset_pin_oe_o,                     // pull-down enable
    input wire logic int_reset_req_i,                // internal reset request pulse
    input wire logic idle_req_i,                     // enter idle pulse
    input wire logic standby_req_i,                  // enter standby pulse
    input wire logic pdown_req_i,                    // enter powerdown pulse
    input wire logic wake_i,                         // wake event from low-power mode
    input wire logic powerdown_return_timing_i,      // timing pin, high = delay passed
    input wire logic [1:0] clock_multiplier_select_i, // multiplier select pins
    input wire logic [23:0] cpu_addr_i,              // cpu address to decode
    output logic chip_rst_o,                         // internal reset, high
    output logic cpu_clk_en_o,                       // cpu clock enable
    output logic periph_clk_en_o,                    // peripheral clock enable
    output logic [2:0] mode_o,                       // power mode state
    output logic [2:0] mult_factor_o,                // clock multiplication factor
    output logic mult_en_o,                          // multiplier circuitry enabled
    output logic mult_reserved_o,                    // unsupported select combination
    output logic fetch_valid_o,                      // first fetch pulse after reset
    output logic [23:0] fetch_addr_o,                // first fetch address
    output logic [RPR_EXT_ADDR_W-1:0] ext_addr_o,    // address on external bus
    output logic ext_sel_o                           // cpu address maps externally
);
    rpr_pd_if pd_if ();

    //////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] pin_sync_r;
    logic [1:0] rpd_sync_r;
    logic [1:0] mult_s1_r;
    logic [1:0] mult_s2_r;
    logic pin_prev_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_sync_r <= RPR_SYNC_RESET;
            rpd_sync_r <= 2'h0;
            mult_s1_r <= 2'h0;
            mult_s2_r <= 2'h0;
            pin_prev_r <= RPR_PIN_IDLE;
        end else begin
            pin_sync_r <= {pin_sync_r[0], reset_pin_i};
            rpd_sync_r <= {rpd_sync_r[0], powerdown_return_timing_i};
            mult_s1_r <= clock_multiplier_select_i;
            mult_s2_r <= mult_s1_r;
            pin_prev_r <= pin_sync_r[1];
        end
    end

    wire pin_low = ~pin_sync_r[1];
    wire pin_fall = pin_prev_r & ~pin_sync_r[1];
    wire rpd_done = rpd_sync_r[1];

    //////////////////////////////////////////////////////////////////
    // pull-down pulse start; own drive-induced edge ignored while busy
    assign pd_if.start = (pin_fall | int_reset_req_i) & ~pd_if.busy;

    rpr_pulldown_timer #(
        .STATES(PD_STATES),
        .STATE_CYC(STATE_CYC)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pd(pd_if)
    );

    wire reset_act = pin_low | pd_if.busy | pd_if.start;

    //////////////////////////////////////////////////////////////////
    // power mode state machine
    rpr_mode_t mode_r;
    rpr_mode_t mode_nxt;
    logic in_reset_r;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            RPR_ST_RUN: begin
                if (pdown_req_i) begin
                    mode_nxt = RPR_ST_PDOWN;
                end else if (standby_req_i) begin
                    mode_nxt = RPR_ST_STANDBY;
                end else if (idle_req_i) begin
                    mode_nxt = RPR_ST_IDLE;
                end
            end
            RPR_ST_IDLE, RPR_ST_STANDBY: begin
                if (wake_i) begin
                    mode_nxt = RPR_ST_RUN;
                end
            end
            RPR_ST_PDOWN: begin
                if (wake_i) begin
                    mode_nxt = RPR_ST_WAKE;
                end
            end
            RPR_ST_WAKE: begin
                if (rpd_done) begin
                    mode_nxt = RPR_ST_RUN;
                end
            end
            default: mode_nxt = RPR_ST_RUN;
        endcase
        if (reset_act) begin
            // oscillator may be stopped in powerdown: still wait on timing pin
            if (mode_r == RPR_ST_PDOWN || mode_r == RPR_ST_WAKE) begin
                mode_nxt = RPR_ST_WAKE;
            end else begin
                mode_nxt = RPR_ST_RUN;
            end
        end
    end

    // clocks gated while reset is held; board keeps pin low long enough for settling
    wire cpu_en_nxt = (mode_nxt == RPR_ST_RUN) & ~reset_act;
    wire per_en_nxt = (mode_nxt == RPR_ST_RUN || mode_nxt == RPR_ST_IDLE) & ~reset_act;

    //////////////////////////////////////////////////////////////////
    // multiplier decode
    logic [2:0] factor_nxt;
    always_comb begin
        case (mult_s2_r)
            RPR_MULT_STANDARD: factor_nxt = RPR_FACTOR_X1;
            RPR_MULT_DOUBLED: factor_nxt = RPR_FACTOR_X2;
            RPR_MULT_QUAD: factor_nxt = RPR_FACTOR_X4;
            default: factor_nxt = RPR_FACTOR_X1;
        endcase
    end
    wire mult_en_nxt = (mult_s2_r != RPR_MULT_STANDARD) && (mult_s2_r != RPR_MULT_RESERVED);

    //////////////////////////////////////////////////////////////////
    // address decode
    wire ext_hit = (cpu_addr_i >= RPR_EXT_WIN_LO) && (cpu_addr_i <= RPR_EXT_WIN_HI);
    wire release_now = in_reset_r & ~reset_act & (mode_nxt == RPR_ST_RUN);
    // internal reset also held through the timing pin wait after a powerdown reset
    wire in_reset_nxt = reset_act | (in_reset_r & (mode_nxt != RPR_ST_RUN));

    //////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r <= RPR_ST_RUN;
            in_reset_r <= 1'b1;
            chip_rst_o <= 1'b1;
            cpu_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            mult_factor_o <= RPR_FACTOR_X1;
            mult_en_o <= 1'b0;
            mult_reserved_o <= 1'b0;
            fetch_valid_o <= 1'b0;
            ext_sel_o <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            in_reset_r <= in_reset_nxt;
            chip_rst_o <= in_reset_nxt;
            cpu_clk_en_o <= cpu_en_nxt;
            periph_clk_en_o <= per_en_nxt;
            mult_factor_o <= factor_nxt;
            mult_en_o <= mult_en_nxt;
            mult_reserved_o <= (mult_s2_r == RPR_MULT_RESERVED);
            fetch_valid_o <= release_now;
            ext_sel_o <= ext_hit;
        end
    end

    assign reset_pin_o = 1'b0;
    // timer busy flop drives the pull-down directly: exactly the pulse length
    assign reset_pin_oe_o = pd_if.busy;
    assign mode_o = mode_r;
    assign fetch_addr_o = RPR_RESET_VECTOR;
    assign ext_addr_o = RPR_RESET_VECTOR[RPR_EXT_ADDR_W-1:0];
endmodule // rpr_reset_seq
`default_nettype wire

// *** verif/rpr_reset_seq_assertions.sv ***
// concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rpr_reset_seq_assertions
    import rpr_pkg::*;
#(
    parameter int unsigned PD_STATES = RPR_PULLDOWN_STATES,
    parameter int unsigned STATE_CYC = RPR_STATE_CYCLES
) (
    input wire logic ref_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic int_reset_req_i, // internal request
    input wire logic [1:0] clock_multiplier_select_i, // select pins
    input wire logic [23:0] cpu_addr_i, // decoded address
    input wire logic reset_pin_o, // pin drive value
    input wire logic reset_pin_oe_o, // pull-down enable
    input wire logic chip_rst_o, // internal reset
    input wire logic cpu_clk_en_o, // cpu enable
    input wire logic periph_clk_en_o, // peripheral enable
    input wire logic [2:0] mode_o, // mode
    input wire logic [2:0] mult_factor_o, // factor
    input wire logic mult_en_o, // multiplier on
    input wire logic fetch_valid_o, // fetch pulse
    input wire logic [23:0] fetch_addr_o, // fetch address
    input wire logic [19:0] ext_addr_o, // external address
    input wire logic ext_sel_o // external select
);
    logic [7:0] oe_cnt_r;
    logic [1:0] s;
    logic [2:0] exp_fac;
    assign s = clock_multiplier_select_i;
    assign exp_fac = (s == RPR_MULT_QUAD) ? RPR_FACTOR_X4 : (s == RPR_MULT_DOUBLED) ? RPR_FACTOR_X2 : RPR_FACTOR_X1;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) oe_cnt_r <= 8'h00;
        else oe_cnt_r <= reset_pin_oe_o ? oe_cnt_r + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_drive_low; reset_pin_o == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low) else $error("pin driven high");
    property p_pulse_len; $fell(reset_pin_oe_o) |-> oe_cnt_r == 8'(PD_STATES * STATE_CYC); endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pull-down length wrong");
    property p_int_start; int_reset_req_i && !reset_pin_oe_o && !chip_rst_o |=> reset_pin_oe_o && chip_rst_o; endproperty
    a_int_start: assert property (p_int_start) else $error("internal reset not started");
    property p_hold_rst; reset_pin_oe_o |-> chip_rst_o; endproperty
    a_hold_rst: assert property (p_hold_rst) else $error("reset released during pulse");
    property p_gate_rst; chip_rst_o |-> !cpu_clk_en_o && !periph_clk_en_o; endproperty
    a_gate_rst: assert property (p_gate_rst) else $error("clocks on in reset");
    property p_gate_wake; mode_o == 3'(RPR_ST_WAKE) |-> !cpu_clk_en_o && !periph_clk_en_o; endproperty
    a_gate_wake: assert property (p_gate_wake) else $error("clocks on before timing pin");
    property p_fetch; fetch_valid_o |-> $past(chip_rst_o) && fetch_addr_o == 24'hFF2080 && ext_addr_o == 20'hF2080; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address wrong");
    property p_ext; !$past(rst_i) |-> ext_sel_o == ($past(cpu_addr_i) >= 24'hFF2000 && $past(cpu_addr_i) <= 24'hFF2FFF);
    endproperty
    a_ext: assert property (p_ext) else $error("external decode wrong");
    property p_mult; !$past(rst_i, 3) && s == $past(s) && s == $past(s, 2) && s == $past(s, 3)
        |-> mult_factor_o == exp_fac && mult_en_o == (s != RPR_MULT_STANDARD && s != RPR_MULT_RESERVED); endproperty
    a_mult: assert property (p_mult) else $error("multiplier output wrong");
    c_pulse: cover property ($rose(reset_pin_oe_o));
    c_wake: cover property (mode_o == 3'(RPR_ST_WAKE));
    c_fetch: cover property (fetch_valid_o);
endmodule // rpr_reset_seq_assertions
bind rpr_reset_seq rpr_reset_seq_assertions #(.PD_STATES(PD_STATES), .STATE_CYC(STATE_CYC)) i_rpr_reset_seq_assertions (.*);
`default_nettype wire

// *** verif/rpr_board.sv ***
// board reset circuit with pull-up and powerdown timing capacitor
`timescale 1ns/1ps
`default_nettype none
module rpr_board #(
    parameter int unsigned CAP_CYC = 8
) (
    input wire logic ref_clk_i, // clock
    input wire logic oe_i, // device pull-down
    input wire logic hold_low_i, // board pulls reset low
    input wire logic charge_i, // capacitor charging
    output logic pin_o, // reset pin level
    output logic timing_o // timing pin level
);
    logic [7:0] cap_r = 8'h00;
    assign pin_o = !(oe_i || hold_low_i);
    always_ff @(posedge ref_clk_i) begin
        if (!charge_i) cap_r <= 8'h00;
        else if (cap_r < 8'(CAP_CYC)) cap_r <= cap_r + 8'h01;
    end
    assign timing_o = cap_r >= 8'(CAP_CYC);
endmodule // rpr_board
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the reset and powerdown return logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rpr_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, int_reset_req_i = 1'b0, idle_req_i = 1'b0, standby_req_i = 1'b0;
    logic pdown_req_i = 1'b0, wake_i = 1'b0, hold_low = 1'b0, charge = 1'b1;
    logic [1:0] clock_multiplier_select_i = 2'h0;
    logic [23:0] cpu_addr_i = 24'h000000;
    wire logic reset_pin_i, powerdown_return_timing_i;
    logic reset_pin_o, reset_pin_oe_o, chip_rst_o, cpu_clk_en_o, periph_clk_en_o, mult_en_o, mult_reserved_o;
    logic fetch_valid_o, ext_sel_o;
    logic [2:0] mode_o, mult_factor_o;
    logic [23:0] fetch_addr_o;
    logic [19:0] ext_addr_o;
    int num_errors = 0, n_compared = 0, cyc = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    rpr_board i_rpr_board (.ref_clk_i, .oe_i(reset_pin_oe_o), .hold_low_i(hold_low), .charge_i(charge),
        .pin_o(reset_pin_i), .timing_o(powerdown_return_timing_i));
    rpr_reset_seq i_rpr_reset_seq (.ref_clk_i, .rst_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .int_reset_req_i,
        .idle_req_i, .standby_req_i, .pdown_req_i, .wake_i, .powerdown_return_timing_i, .clock_multiplier_select_i,
        .cpu_addr_i, .chip_rst_o, .cpu_clk_en_o, .periph_clk_en_o, .mode_o, .mult_factor_o, .mult_en_o,
        .mult_reserved_o, .fetch_valid_o, .fetch_addr_o, .ext_addr_o, .ext_sel_o);
    task automatic tick(); @(posedge ref_clk_i); #1; endtask
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic wait_done();
        for (int n = 0; n < 100 && chip_rst_o !== 1'b0; n++) tick();
        chk("fetch_valid", 24'(fetch_valid_o), 24'h1);
        chk("fetch_addr", fetch_addr_o, 24'hFF2080);
        chk("ext_addr", 24'(ext_addr_o), 24'h0F2080);
        chk("mode", 24'(mode_o), 24'(RPR_ST_RUN));
        tick();
    endtask
    task automatic t_int();
        int n = 0;
        int_reset_req_i = 1'b1;
        tick();
        int_reset_req_i = 1'b0;
        chk("chip_rst", 24'(chip_rst_o), 24'h1);
        while (reset_pin_oe_o === 1'b1 && n < 100) begin
            tick();
            n++;
        end
        chk("pulse", 24'(n), 24'(RPR_PULLDOWN_STATES));
        wait_done();
    endtask
    task automatic t_pin(input int k);
        logic [2:0] m[2] = '{3'(RPR_ST_IDLE), 3'(RPR_ST_STANDBY)};
        if (k < 2) begin
            {standby_req_i, idle_req_i} = 2'(1 << k);
            tick();
            {standby_req_i, idle_req_i} = 2'h0;
            tick();
            chk("mode", 24'(mode_o), 24'(m[k]));
            chk("periph_en", 24'(periph_clk_en_o), 24'(k == 0));
        end
        hold_low = 1'b1;
        repeat (28) tick();
        chk("oe_after_pulse", 24'(reset_pin_oe_o), 24'h0);
        chk("chip_rst_pin_low", 24'(chip_rst_o), 24'h1);
        hold_low = 1'b0;
        wait_done();
    endtask
    task automatic t_pdown();
        charge = 1'b0;
        pdown_req_i = 1'b1;
        tick();
        pdown_req_i = 1'b0;
        tick();
        chk("mode", 24'(mode_o), 24'(RPR_ST_PDOWN));
        wake_i = 1'b1;
        tick();
        wake_i = 1'b0;
        repeat (10) tick();
        chk("mode", 24'(mode_o), 24'(RPR_ST_WAKE));
        chk("cpu_en", 24'(cpu_clk_en_o), 24'h0);
        charge = 1'b1;
        for (int n = 0; n < 50 && mode_o !== 3'(RPR_ST_RUN); n++) tick();
        tick();
        chk("cpu_en", 24'(cpu_clk_en_o), 24'h1);
        charge = 1'b0;
        pdown_req_i = 1'b1;
        tick();
        pdown_req_i = 1'b0;
        hold_low = 1'b1;
        repeat (28) tick();
        chk("mode_pd_rst", 24'(mode_o), 24'(RPR_ST_WAKE));
        hold_low = 1'b0;
        repeat (6) tick();
        chk("mode_wait_rpd", 24'(mode_o), 24'(RPR_ST_WAKE));
        chk("cpu_en_wait_rpd", 24'(cpu_clk_en_o), 24'h0);
        chk("chip_rst_wait_rpd", 24'(chip_rst_o), 24'h1);
        charge = 1'b1;
        wait_done();
    endtask
    task automatic t_mult();
        logic [2:0] f[4] = '{RPR_FACTOR_X1, RPR_FACTOR_X2, RPR_FACTOR_X1, RPR_FACTOR_X4};
        for (int s = 0; s < 4; s++) begin
            clock_multiplier_select_i = 2'(s);
            repeat (4) tick();
            chk("factor", 24'(mult_factor_o), 24'(f[s]));
            chk("mult_en", 24'(mult_en_o), 24'(s == 1 || s == 3));
            chk("reserved", 24'(mult_reserved_o), 24'(s == 2));
        end
    endtask
    task automatic t_addr();
        logic [23:0] a[4] = '{24'hFF1FFF, 24'hFF2000, 24'hFF2FFF, 24'hFF3000};
        for (int i = 0; i < 4; i++) begin
            cpu_addr_i = a[i];
            tick();
            chk("ext_sel", 24'(ext_sel_o), 24'(i == 1 || i == 2));
        end
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        wait_done();
        t_int();
        for (int k = 0; k < 3; k++) t_pin(k);
        t_pdown();
        t_mult();
        t_addr();
        stop_test();
    end
endmodule // tb
`default_nettype wire
